// >>> bct_bp_model.sv
// backplane partner: bit clock, frame pulse and per-frame output counts
`default_nettype none
`timescale 1ns/10ps
module bct_bp_model (
	output logic bp_clk,
	output logic [7:0] sync_pin,
	output logic fend,
	output logic [47:0] report,
	input wire logic inv,
	input wire logic [11:0] frame_len,
	input wire logic rx_blk,
	input wire logic tx_blk,
	input wire logic rx_clk,
	input wire logic tx_clk
);
	logic [11:0] bit_q = 12'h000;
	logic [7:0] rf = 8'hff, tf = 8'hff, rb = 8'h00, tb = 8'h00, rc = 8'h00, tc = 8'h00;
	logic rh = 1'b0, th = 1'b0;
	logic last;
	assign last = bit_q >= frame_len - 12'h001;
	initial begin
		bp_clk = 1'b0;
		fend = 1'b0;
		sync_pin = 8'h00;
		#1.3;
		forever #16 bp_clk = ~bp_clk;
	end
	// gapped pulses live in the low phase, so latch them for the next edge
	always @(posedge rx_clk) rh = 1'b1;
	always @(posedge tx_clk) th = 1'b1;
	always @(posedge bp_clk) begin
		bit_q <= last ? 12'h000 : bit_q + 12'h001;
		// pulse on pin 0 only, unused pins rest at the idle level
		sync_pin <= {{7{inv}}, inv ^ last};
		report <= {rf, tf, rb + 8'(rx_blk), tb + 8'(tx_blk), rc + 8'(rh), tc + 8'(th)};
		fend <= last;
		rb <= last ? 8'h00 : rb + 8'(rx_blk);
		tb <= last ? 8'h00 : tb + 8'(tx_blk);
		rc <= last ? 8'h00 : rc + 8'(rh);
		tc <= last ? 8'h00 : tc + 8'(th);
		rf <= last ? 8'hff : (rx_blk && rf == 8'hff) ? bit_q[7:0] : rf;
		tf <= last ? 8'hff : (tx_blk && tf == 8'hff) ? bit_q[7:0] : tf;
		rh = 1'b0;
		th = 1'b0;
	end
endmodule : bct_bp_model
`default_nettype wire

// >>> bct_chan_timer.sv
// per-path channel timing: frame counter, blocking output and gapped clock
`default_nettype none
`timescale 1ns/10ps
module bct_chan_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_in,
	input wire logic ctbus,
	input wire logic invert,
	input wire logic e1,
	input wire logic [1:0] interleaved_bus_option,
	input wire logic [2:0] port,
	input wire logic [31:0] blk_mask,
	input wire logic [31:0] gap_mask,
	input wire logic gap_en,
	input wire logic fmt56,
	output logic block_out,
	output logic chclk_out,
	output logic locked
);
	// ==========================================================
	// frame sync and bit counter
	logic s_prev_q;
	logic locked_q;
	logic [10:0] cnt_q;
	logic [10:0] cnt_d;
	logic block_q;
	logic gate_q;
	wire sync_lvl = sync_in ^ invert;
	wire sync_rise = sync_lvl & ~s_prev_q;
	wire wide = e1 | (interleaved_bus_option != 2'h0);
	wire [11:0] frame_len = wide ? 12'(bct_pkg::E1_FRAME_BITS << interleaved_bus_option) : bct_pkg::T1_FRAME_BITS;
	wire [10:0] cnt_last = 11'(frame_len - 12'h001);
	wire [10:0] preload = ctbus ? bct_pkg::PRELOAD_CTBUS : bct_pkg::PRELOAD_STD;
	always_comb begin
		if (sync_rise) begin
			cnt_d = preload;
		end else if (cnt_q == cnt_last) begin
			cnt_d = 11'h000;
		end else begin
			cnt_d = 11'(cnt_q + 11'h001);
		end
	end
	// ==========================================================
	// channel position of the coming bit
	wire f_bit = ~wide & (cnt_d == 11'h000);
	wire [10:0] pos = wide ? cnt_d : 11'(cnt_d - 11'h001);
	wire [7:0] byte_idx = pos[10:3];
	wire [2:0] bit_idx = pos[2:0];
	wire [2:0] slot_mask = ~3'(3'h7 << interleaved_bus_option);
	wire own_slot = (byte_idx[2:0] & slot_mask) == (port & slot_mask);
	wire [7:0] ch_wide = byte_idx >> interleaved_bus_option;
	wire [4:0] ch = ch_wide[4:0];
	wire active = locked_q & ~f_bit & own_slot;
	wire drop_lsb = fmt56 & (bit_idx == bct_pkg::LSB_BIT_POS);
	wire block_d = active & blk_mask[ch];
	wire gate_d = active & gap_en & gap_mask[ch] & ~drop_lsb;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_prev_q <= 1'b0;
			locked_q <= 1'b0;
			cnt_q <= 11'h000;
			block_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			s_prev_q <= sync_lvl;
			locked_q <= locked_q | sync_rise;
			cnt_q <= cnt_d;
			block_q <= block_d;
			gate_q <= gate_d;
		end
	end
	// gate changes at the rising edge while the high phase masks it
	assign chclk_out = gate_q & ~clk;
	assign block_out = block_q;
	assign locked = locked_q;
endmodule : bct_chan_timer
`default_nettype wire

// >>> bct_pkg.sv
// constants, types and helpers shared by the backplane channel timing block
`default_nettype none
package bct_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] RIO_OFF = 8'h00;
	localparam logic [7:0] TIO_OFF = 8'h04;
	localparam logic [7:0] RESC_OFF = 8'h08;
	localparam logic [7:0] TESC_OFF = 8'h0c;
	localparam logic [7:0] BPC_OFF = 8'h10;
	localparam logic [7:0] STAT_OFF = 8'h14;
	localparam logic [3:0] SEL_GRP_FIRST = 4'h2;
	localparam logic [3:0] SEL_GRP_LAST = 4'h5;
	// ==========================================================
	// field positions
	localparam int CTBUS_BIT = 5;
	localparam int SYNC_INV_BIT = 4;
	localparam int GAP_EN_BIT = 6;
	localparam int FMT56_BIT = 7;
	localparam int BPC_E1_BIT = 0;
	localparam int BPC_IBO_LSB = 1;
	localparam int BPC_PORT_LSB = 4;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_RXLOCK_BIT = 1;
	localparam int STAT_TXLOCK_BIT = 2;
	// ==========================================================
	// reset values and bus answers
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// backplane timing counts
	localparam logic [11:0] T1_FRAME_BITS = 12'h0c1;
	localparam logic [11:0] E1_FRAME_BITS = 12'h100;
	localparam logic [10:0] PRELOAD_STD = 11'h003;
	localparam logic [10:0] PRELOAD_CTBUS = 11'h002;
	localparam logic [2:0] LSB_BIT_POS = 3'h7;
	localparam int CTRL_W = 13;
	localparam int CFG_W = 141;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		REG_NONE = 3'h0,
		REG_RIO = 3'h1,
		REG_TIO = 3'h2,
		REG_RESC = 3'h3,
		REG_TESC = 3'h4,
		REG_BPC = 3'h5,
		REG_STAT = 3'h6,
		REG_SEL = 3'h7
	} bct_reg_e;
	// interleave: 0 none, 1 two ports, 2 four ports, 3 eight ports
	typedef logic [1:0] bct_ibo_t;
	// ==========================================================
	// which sync pin carries the frame pulse for a port
	function automatic logic [2:0] sync_pin_index(input bct_ibo_t interleaved_bus_option, input logic [2:0] port);
		sync_pin_index = port & 3'(3'h7 << interleaved_bus_option);
	endfunction : sync_pin_index
endpackage : bct_pkg
`default_nettype wire

// >>> bct_top.sv
// backplane channel timing: register slave, config crossing and both paths
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`default_nettype none
`timescale 1ns/10ps
module bct_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bp_clk,
	input wire logic [7:0] receive_sync_pin,
	input wire logic [7:0] transmit_system_sync_pin,
	output logic receive_channel_block_out,
	output logic transmit_channel_block_out,
	output logic receive_channel_clock_out,
	output logic transmit_channel_clock_out
);
	// ==========================================================
	// address decode
	function automatic bct_pkg::bct_reg_e decode(input logic [7:0] a);
		if (a[1:0] != 2'h0) begin
			decode = bct_pkg::REG_NONE;
		end else if (a[7:4] >= bct_pkg::SEL_GRP_FIRST && a[7:4] <= bct_pkg::SEL_GRP_LAST) begin
			decode = bct_pkg::REG_SEL;
		end else begin
			case (a)
				bct_pkg::RIO_OFF: decode = bct_pkg::REG_RIO;
				bct_pkg::TIO_OFF: decode = bct_pkg::REG_TIO;
				bct_pkg::RESC_OFF: decode = bct_pkg::REG_RESC;
				bct_pkg::TESC_OFF: decode = bct_pkg::REG_TESC;
				bct_pkg::BPC_OFF: decode = bct_pkg::REG_BPC;
				bct_pkg::STAT_OFF: decode = bct_pkg::REG_STAT;
				default: decode = bct_pkg::REG_NONE;
			endcase
		end
	endfunction : decode
	function automatic logic [3:0] sel_index(input logic [7:0] a);
		logic [3:0] grp;
		grp = 4'(a[7:4] - bct_pkg::SEL_GRP_FIRST);
		sel_index = {grp[1:0], a[3:2]};
	endfunction : sel_index
	// ==========================================================
	// registers
	logic [7:0] rio_q;
	logic [7:0] tio_q;
	logic [7:0] resc_q;
	logic [7:0] tesc_q;
	logic [7:0] bpc_q;
	logic [7:0] sel_q [16];
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	// ==========================================================
	// write channel: address and data taken in either order
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_hold_q & w_hold_q;
	wire bct_pkg::bct_reg_e wr_reg = decode(awaddr_q);
	wire wr_hit = do_write & (wr_reg != bct_pkg::REG_NONE) & wstrb0_q;
	wire [3:0] wr_idx = sel_index(awaddr_q);
	assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
	assign s_axi_wready = ~w_hold_q & ~bvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= bct_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wr_reg == bct_pkg::REG_NONE) ? bct_pkg::RESP_SLVERR
					: bct_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rio_q <= bct_pkg::REG_RESET;
			tio_q <= bct_pkg::REG_RESET;
			resc_q <= bct_pkg::REG_RESET;
			tesc_q <= bct_pkg::REG_RESET;
			bpc_q <= bct_pkg::REG_RESET;
			for (int i = 0; i < 16; i++) begin
				sel_q[i] <= bct_pkg::REG_RESET;
			end
		end else if (wr_hit) begin
			case (wr_reg)
				bct_pkg::REG_RIO: rio_q <= wdata_q;
				bct_pkg::REG_TIO: tio_q <= wdata_q;
				bct_pkg::REG_RESC: resc_q <= wdata_q;
				bct_pkg::REG_TESC: tesc_q <= wdata_q;
				bct_pkg::REG_BPC: bpc_q <= wdata_q;
				bct_pkg::REG_SEL: sel_q[wr_idx] <= wdata_q;
				default: rio_q <= rio_q;
			endcase
		end
	end
	// ==========================================================
	// read channel
	logic pend;
	logic rx_lock_s1_q;
	logic rx_lock_s2_q;
	logic tx_lock_s1_q;
	logic tx_lock_s2_q;
	wire bct_pkg::bct_reg_e rd_reg = decode(s_axi_araddr);
	wire [3:0] rd_idx = sel_index(s_axi_araddr);
	wire [7:0] status_val = 8'({tx_lock_s2_q, rx_lock_s2_q, pend});
	logic [7:0] rd_val;
	always_comb begin
		case (rd_reg)
			bct_pkg::REG_RIO: rd_val = rio_q;
			bct_pkg::REG_TIO: rd_val = tio_q;
			bct_pkg::REG_RESC: rd_val = resc_q;
			bct_pkg::REG_TESC: rd_val = tesc_q;
			bct_pkg::REG_BPC: rd_val = bpc_q;
			bct_pkg::REG_STAT: rd_val = status_val;
			bct_pkg::REG_SEL: rd_val = sel_q[rd_idx];
			default: rd_val = 8'h00;
		endcase
	end
	assign s_axi_arready = ~rvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= bct_pkg::RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (s_axi_arvalid & ~rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_val};
			rresp_q <= (rd_reg == bct_pkg::REG_NONE) ? bct_pkg::RESP_SLVERR
				: bct_pkg::RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	// ==========================================================
	// configuration snapshot handed to the backplane by toggle handshake
	logic dirty_q;
	logic req_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_q;
	logic rx_locked;
	logic tx_locked;
	logic [bct_pkg::CFG_W-1:0] xfer_q;
	wire [bct_pkg::CTRL_W-1:0] ctrl_live = {
		bpc_q[bct_pkg::BPC_PORT_LSB +: 3], bpc_q[bct_pkg::BPC_IBO_LSB +: 2],
		bpc_q[bct_pkg::BPC_E1_BIT],
		tesc_q[bct_pkg::FMT56_BIT], tesc_q[bct_pkg::GAP_EN_BIT],
		resc_q[bct_pkg::FMT56_BIT], resc_q[bct_pkg::GAP_EN_BIT],
		tio_q[bct_pkg::SYNC_INV_BIT], rio_q[bct_pkg::SYNC_INV_BIT],
		rio_q[bct_pkg::CTBUS_BIT]};
	wire [bct_pkg::CFG_W-1:0] cfg_live = {
		sel_q[3], sel_q[2], sel_q[1], sel_q[0], sel_q[7], sel_q[6], sel_q[5], sel_q[4],
		sel_q[11], sel_q[10], sel_q[9], sel_q[8], sel_q[15], sel_q[14], sel_q[13], sel_q[12],
		ctrl_live};
	assign pend = req_q ^ ack_s2_q;
	wire launch = dirty_q & ~pend;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dirty_q <= 1'b0;
			req_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			rx_lock_s1_q <= 1'b0;
			rx_lock_s2_q <= 1'b0;
			tx_lock_s1_q <= 1'b0;
			tx_lock_s2_q <= 1'b0;
			xfer_q <= '0;
		end else begin
			// a write in the launch cycle keeps the flag set
			dirty_q <= wr_hit | (dirty_q & ~launch);
			req_q <= req_q ^ launch;
			if (launch) begin
				xfer_q <= cfg_live;
			end
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
			rx_lock_s1_q <= rx_locked;
			rx_lock_s2_q <= rx_lock_s1_q;
			tx_lock_s1_q <= tx_locked;
			tx_lock_s2_q <= tx_lock_s1_q;
		end
	end
	// ==========================================================
	// backplane domain
	logic [1:0] bp_rst_q;
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic [bct_pkg::CFG_W-1:0] cfg_q;
	logic [7:0] rs_s1_q;
	logic [7:0] rs_s2_q;
	logic [7:0] ts_s1_q;
	logic [7:0] ts_s2_q;
	wire bp_rst_n = bp_rst_q[1];
	always_ff @(posedge bp_clk) begin
		bp_rst_q <= {bp_rst_q[0], aresetn};
	end
	always_ff @(posedge bp_clk) begin
		if (!bp_rst_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			ack_q <= 1'b0;
			cfg_q <= '0;
			rs_s1_q <= 8'h00;
			rs_s2_q <= 8'h00;
			ts_s1_q <= 8'h00;
			ts_s2_q <= 8'h00;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			if (req_s2_q ^ req_s3_q) begin
				cfg_q <= xfer_q;
				ack_q <= req_s2_q;
			end
			rs_s1_q <= receive_sync_pin;
			rs_s2_q <= rs_s1_q;
			ts_s1_q <= transmit_system_sync_pin;
			ts_s2_q <= ts_s1_q;
		end
	end
	wire bp_ctbus = cfg_q[0];
	wire bp_e1 = cfg_q[7];
	wire [1:0] bp_ibo = cfg_q[9:8];
	wire [2:0] bp_port = cfg_q[12:10];
	wire [2:0] pin_idx = bct_pkg::sync_pin_index(bp_ibo, bp_port);
	wire [31:0] tx_gap_mask = cfg_q[44:13];
	wire [31:0] rx_gap_mask = cfg_q[76:45];
	wire [31:0] tx_blk_raw = cfg_q[108:77];
	wire [31:0] rx_blk_mask = cfg_q[140:109];
	wire [31:0] tx_blk_mask = {tx_blk_raw[31:24] & {8{bp_e1}}, tx_blk_raw[23:0]};
	bct_chan_timer u_rx (
		.clk(bp_clk),
		.rst_n(bp_rst_n),
		.sync_in(rs_s2_q[pin_idx]),
		.ctbus(bp_ctbus),
		.invert(cfg_q[1]),
		.e1(bp_e1),
		.interleaved_bus_option(bp_ibo),
		.port(bp_port),
		.blk_mask(rx_blk_mask),
		.gap_mask(rx_gap_mask),
		.gap_en(cfg_q[3]),
		.fmt56(cfg_q[4]),
		.block_out(receive_channel_block_out),
		.chclk_out(receive_channel_clock_out),
		.locked(rx_locked)
	);
	bct_chan_timer u_tx (
		.clk(bp_clk),
		.rst_n(bp_rst_n),
		.sync_in(ts_s2_q[pin_idx]),
		.ctbus(bp_ctbus),
		.invert(cfg_q[2]),
		.e1(bp_e1),
		.interleaved_bus_option(bp_ibo),
		.port(bp_port),
		.blk_mask(tx_blk_mask),
		.gap_mask(tx_gap_mask),
		.gap_en(cfg_q[5]),
		.fmt56(cfg_q[6]),
		.block_out(transmit_channel_block_out),
		.chclk_out(transmit_channel_clock_out),
		.locked(tx_locked)
	);
endmodule : bct_top
`default_nettype wire

// >>> bct_top_checker.sv
// assertion checker watching the backplane channel timing top module
`default_nettype none
`timescale 1ns/10ps
module bct_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bp_clk,
	input wire logic receive_channel_block_out,
	input wire logic transmit_channel_block_out,
	input wire logic receive_channel_clock_out,
	input wire logic transmit_channel_clock_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ========
	// register bus
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response missing");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data not held");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	// ========
	// backplane outputs
	rx_gap_phase_a: assert property (receive_channel_clock_out |-> !bp_clk)
		else $error("receive channel clock in high phase");
	tx_gap_phase_a: assert property (transmit_channel_clock_out |-> !bp_clk)
		else $error("transmit channel clock in high phase");
	bit_edge_a: assert property ($changed(receive_channel_block_out)
		|| $changed(transmit_channel_block_out) |-> bp_clk) else $error("block off bit edge");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(receive_channel_block_out));
endmodule : bct_top_checker
bind bct_top bct_top_checker u_chk (.*);
`default_nettype wire

// >>> tb_top.sv
// self-checking bench: register bus access and backplane channel timing
`default_nettype none
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("ERROR t=%0t got %0h expected %0h", $time, got, exp); \
		end \
	end
module tb_top;
	localparam int OFS = 0;
	localparam logic [1:0] OK = bct_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = bct_pkg::RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0, inv = 1'b0, grab = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sync_pin;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h0661;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bp_clk, fend;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] frame_len = 12'h100;
	logic [47:0] report, lk_e, exp_lk[$];
	logic [33:0] bus_e, exp_bus[$];
	logic receive_channel_block_out, transmit_channel_block_out;
	logic receive_channel_clock_out, transmit_channel_clock_out;
	logic [15:0] cfg[8] = '{16'h1001, 16'h2005, 16'h3002, 16'h3c01, 16'h4001, 16'h5001,
		16'h0840, 16'h0cc0};
	int compares = 0, fail_count = 0;
	bct_top dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .bp_clk, .receive_sync_pin(sync_pin),
		.transmit_system_sync_pin(sync_pin), .receive_channel_block_out,
		.transmit_channel_block_out, .receive_channel_clock_out, .transmit_channel_clock_out
	);
	bct_bp_model u_bp (
		.bp_clk, .sync_pin, .fend, .report, .inv, .frame_len,
		.rx_blk(receive_channel_block_out), .tx_blk(transmit_channel_block_out),
		.rx_clk(receive_channel_clock_out), .tx_clk(transmit_channel_clock_out)
	);
	always #2 aclk = ~aclk;
	// ========
	// helpers
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xorshift = y ^ (y << 5);
	endfunction : xorshift
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		exp_bus.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_ok) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				b_ok = 1'b1;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_bus.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		// ready stays high so a following call never assigns it twice in one step
	endtask : axi_rd
	// skip two frames so setup and counter realign, then judge a whole one
	task automatic link_chk(input logic [11:0] len, input logic iv, input logic [47:0] e);
		frame_len <= len;
		inv <= iv;
		repeat (2) @(posedge fend);
		exp_lk.push_back(e);
		@(posedge aclk);
		grab <= 1'b1;
		@(posedge fend);
		@(posedge aclk);
		grab <= 1'b0;
		$display("link check done, frame of %0d bits", len);
	endtask : link_chk
	// ========
	// monitors and sequence
	always @(posedge aclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			bus_e = exp_bus.pop_front();
			`CHK(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, bus_e)
		end
	end
	always @(posedge fend) begin
		if (grab) begin
			lk_e = exp_lk.pop_front();
			`CHK(report, lk_e)
		end
	end
	initial begin
		#390000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge bp_clk);
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(8'h00, 32'h0, OK);
		axi_wr(8'h18, 32'h1, ERR);
		axi_rd(8'h18, 32'h0, ERR);
		axi_wr(8'h21, 32'h1, ERR);
		for (int i = 0; i < 4; i++) begin
			rnd = xorshift(rnd);
			axi_wr(8'h44 + 8'(4 * i), rnd, OK);
			axi_rd(8'h44 + 8'(4 * i), {24'h0, rnd[7:0]}, OK);
			axi_wr(8'h44 + 8'(4 * i), 32'h0, OK);
		end
		$display("register test done");
		for (int i = 0; i < 8; i++)
			axi_wr(cfg[i][15:8], {24'h0, cfg[i][7:0]}, OK);
		link_chk(12'h100, 1'b0, {8'(OFS), 8'(8 + OFS), 32'h10100807});
		axi_rd(8'h14, 32'h6, OK);
		axi_wr(8'h0c, 32'h80, OK);
		axi_wr(8'h00, 32'h20, OK);
		link_chk(12'h100, 1'b0, {8'(1 + OFS), 8'(9 + OFS), 32'h10100800});
		axi_wr(8'h00, 32'h30, OK);
		axi_wr(8'h04, 32'h10, OK);
		axi_rd(8'h00, 32'h30, OK);
		link_chk(12'h100, 1'b1, {8'(1 + OFS), 8'(9 + OFS), 32'h10100800});
		axi_wr(8'h00, 32'h0, OK);
		axi_wr(8'h04, 32'h0, OK);
		axi_wr(8'h0c, 32'hc0, OK);
		axi_wr(8'h10, 32'h0, OK);
		link_chk(12'hc1, 1'b0, {8'(1 + OFS), 8'(9 + OFS), 32'h10080807});
		axi_wr(8'h10, 32'h57, OK);
		link_chk(12'h800, 1'b0, {8'(40 + OFS), 8'(104 + OFS), 32'h10100807});
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
